// *** include/csb_params.svh ***
// constants for the compare, skip and branch execution block
// What this block does
// - compares subtract, discard result, update five flags
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - selected flag set jumps by k plus 1
// - flag clear branches; branches never touch flags
// - zero set branches to pc plus k plus 1
// - zero clear branches to pc plus k plus 1
// - carry set branches to pc plus k plus 1
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH
// ----------------------------------------
// widths
// ----------------------------------------
`define CSB_PC_W      16
`define CSB_OFS_W     7
// ----------------------------------------
// status flag bit positions
// ----------------------------------------
`define CSB_FLAG_C    3'd0
`define CSB_FLAG_Z    3'd1
`define CSB_FLAG_N    3'd2
`define CSB_FLAG_V    3'd3
`define CSB_FLAG_H    3'd5
// ----------------------------------------
// reset values and program counter steps
// ----------------------------------------
`define CSB_PC_RST    16'h0000
`define CSB_FLAGS_RST 8'h00
`define CSB_STEP_ONE  16'h0001
`define CSB_STEP_SKIP1 16'h0002
`define CSB_STEP_SKIP2 16'h0003
`endif

// *** include/csb_pkg.sv ***
// type package for the compare, skip and branch execution block
package csb_pkg;
  // operation selected for the current instruction
  typedef enum logic [3:0] {
    CSB_OP_OTHER          = 4'b0000,
    CSB_OP_COMPARE_REGISTERS   = 4'b0001,
    CSB_OP_COMPARE_WITH_CARRY  = 4'b0010,
    CSB_OP_COMPARE_WITH_IMMEDIATE = 4'b0011,
    CSB_OP_SKIP_IF_REG_BIT_CLEAR = 4'b0100,
    CSB_OP_SKIP_IF_REG_BIT_SET   = 4'b0101,
    CSB_OP_SKIP_IF_IO_BIT_CLEAR  = 4'b0110,
    CSB_OP_SKIP_IF_IO_BIT_SET    = 4'b0111,
    CSB_OP_BRANCH_IF_FLAG_SET    = 4'b1000,
    CSB_OP_BRANCH_IF_FLAG_CLEAR  = 4'b1001,
    CSB_OP_BRANCH_IF_EQUAL       = 4'b1010,
    CSB_OP_BRANCH_IF_NOT_EQUAL   = 4'b1011,
    CSB_OP_BRANCH_IF_CARRY_SET   = 4'b1100,
    CSB_OP_BRANCH_SAME_OR_HIGHER = 4'b1101
  } csb_op_t;
endpackage

// *** sim/compare_skip_branch_exec_test.sv ***
// self-checking bench for the compare, skip and branch execution unit
`timescale 1ns/10ps
`default_nettype none
`include "csb_params.svh"
module compare_skip_branch_exec_test
  import csb_pkg::*;
;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic        mclk, resetn, exec_valid, next_is_two_word, flags_load;
  csb_op_t     exec_op;                           // operation under test
  logic [7:0]  operand_d, operand_r, test_byte, flags_in;
  logic [2:0]  bit_sel;                           // bit b or flag s
  logic [6:0]  branch_offset;                     // signed k
  logic [15:0] pc, exp_pc;                        // observed and modelled pc
  logic [7:0]  status_flags_register;             // observed flags
  logic        skip_taken, branch_taken, exec_done;
  int          err_total, checks_done;
  csb_exec csb_exec_i (.mclk(mclk), .resetn(resetn), .exec_valid(exec_valid),
    .exec_op(exec_op), .operand_d(operand_d), .operand_r(operand_r), .test_byte(test_byte),
    .bit_sel(bit_sel), .branch_offset(branch_offset), .next_is_two_word(next_is_two_word),
    .flags_load(flags_load), .flags_in(flags_in), .pc(pc),
    .status_flags_register(status_flags_register), .skip_taken(skip_taken),
    .branch_taken(branch_taken), .exec_done(exec_done));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // verdict and end of run
  task automatic wrap_up();
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one comparison, four-state exact
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // whole-register write by the other unit
  task automatic load_flags(input logic [7:0] v);
    @(posedge mclk);
    flags_load <= 1'b1;
    flags_in <= v;
    @(posedge mclk);
    flags_load <= 1'b0;
    #1;
    chk(status_flags_register, v);
  endtask
  // one instruction, then pc, pulses and untouched flags judged
  task automatic run(input csb_op_t op, input logic [7:0] d, r, tb, input logic [2:0] bs,
                     input logic [6:0] k, input logic two, sk, br, fl, input logic [15:0] step);
    logic [7:0] f0;
    f0 = status_flags_register;
    @(posedge mclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    operand_d <= d;
    operand_r <= r;
    test_byte <= tb;
    bit_sel <= bs;
    branch_offset <= k;
    next_is_two_word <= two;
    flags_load <= fl;
    flags_in <= 8'hff;
    @(posedge mclk);
    exec_valid <= 1'b0;
    flags_load <= 1'b0;
    #1;
    exp_pc = exp_pc + step;
    chk(pc, exp_pc);
    chk(skip_taken, sk);
    chk(branch_taken, br);
    chk(exec_done, 1'b1);
    if (op > CSB_OP_COMPARE_WITH_IMMEDIATE) chk(status_flags_register, f0);
  endtask
  // flags a compare should leave, from old flags f
  function automatic logic [7:0] cmp_exp(input logic [7:0] d, r, f, input logic wc);
    logic [8:0] res;
    logic [4:0] hr;
    logic       ci;
    logic [7:0] e;
    ci = wc & f[`CSB_FLAG_C];
    res = {1'b0, d} - {1'b0, r} - {8'h00, ci};
    hr = {1'b0, d[3:0]} - {1'b0, r[3:0]} - {4'h0, ci};
    e = f;
    e[`CSB_FLAG_C] = res[8];
    e[`CSB_FLAG_H] = hr[4];
    e[`CSB_FLAG_N] = res[7];
    e[`CSB_FLAG_V] = (d[7] & ~r[7] & ~res[7]) | (~d[7] & r[7] & res[7]);
    e[`CSB_FLAG_Z] = (res[7:0] == 8'h00) & (~wc | f[`CSB_FLAG_Z]);
    return e;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // compares of all three kinds, borrow chains, a refused flag write
  task automatic t_compare();
    csb_op_t    ops[5] = '{CSB_OP_COMPARE_REGISTERS, CSB_OP_COMPARE_WITH_IMMEDIATE,
                           CSB_OP_COMPARE_WITH_CARRY, CSB_OP_COMPARE_WITH_CARRY, CSB_OP_COMPARE_REGISTERS};
    logic [7:0] ds[5] = '{8'h05, 8'h00, 8'h80, 8'h10, 8'h7f};
    logic [7:0] rs[5] = '{8'h05, 8'h01, 8'h00, 8'h0f, 8'h80};
    logic [7:0] fs[5] = '{8'h00, 8'h00, 8'h03, 8'h03, 8'hc0};
    // plain instruction: advances by one and lets the outside flag write through
    run(CSB_OP_OTHER, 8'h00, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0001);
    chk(status_flags_register, 8'hff);
    for (int i = 0; i < 5; i++) begin
      load_flags(fs[i]);
      run(ops[i], ds[i], rs[i], 8'h00, 3'h0, 7'h00, 1'b0, 1'b0, 1'b0, i == 4, 16'h0001);
      chk(status_flags_register, cmp_exp(ds[i], rs[i], fs[i], ops[i] == CSB_OP_COMPARE_WITH_CARRY));
    end
  endtask
  // every skip kind, every bit, both outcomes, both next sizes
  task automatic t_skip();
    logic       hit;
    logic [7:0] tb;
    load_flags(8'h5a);
    for (int j = 0; j < 4; j++)
      for (int b = 0; b < 8; b++)
        for (int tv = 0; tv < 2; tv++) begin
          hit = (tv[0] == j[0]);
          tb = tv[0] ? (8'h01 << b) : ~(8'h01 << b);
          run(csb_op_t'(4'h4 + 4'(j)), 8'h00, 8'h00, tb, 3'(b), 7'h00, b[0], hit, 1'b0, 1'b0,
              hit ? (b[0] ? 16'h0003 : 16'h0002) : 16'h0001);
        end
  endtask
  // every branch kind against three flag patterns and each flag index
  task automatic t_branch();
    logic [7:0] pats[3] = '{8'h00, 8'hff, 8'h5a};
    logic [6:0] k;
    logic       f, tk;
    for (int p = 0; p < 3; p++) begin
      load_flags(pats[p]);
      for (int o = 8; o < 14; o++)
        for (int s = 0; s < 8; s++) begin
          k = s[0] ? 7'h7d : 7'h05;
          f = (o < 10) ? pats[p][s] : (o < 12) ? pats[p][`CSB_FLAG_Z] : pats[p][`CSB_FLAG_C];
          tk = (f == ~o[0]);
          run(csb_op_t'(4'(o)), 8'h00, 8'h00, 8'h00, 3'(s), k, 1'b0, 1'b0, tk, 1'b0,
              tk ? ({{9{k[6]}}, k} + 16'h0001) : 16'h0001);
        end
    end
  endtask
  // ----------------------------------------
  // clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    {resetn, exec_valid, next_is_two_word, flags_load} = 4'h0;
    exec_op = CSB_OP_OTHER;
    {operand_d, operand_r, test_byte, flags_in} = 32'h0;
    bit_sel = 3'h0;
    branch_offset = 7'h00;
    err_total = 0;
    checks_done = 0;
    exp_pc = 16'h0000;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    chk(pc, 16'h0000);
    chk(status_flags_register, 8'h00);
    t_compare();
    t_skip();
    t_branch();
    wrap_up();
  end
  // hang guard, well past the expected run
  initial begin
    #50000;
    err_total++;
    wrap_up();
  end
endmodule // compare_skip_branch_exec_test
`default_nettype wire

// *** src/csb_cmp_flags.sv ***
// subtractor that yields compare flags without keeping the difference
`timescale 1ns/10ps
`default_nettype none
module csb_cmp_flags (
  input  wire logic [7:0] minuend,     // rd operand
  input  wire logic [7:0] subtrahend,  // rr operand or immediate
  input  wire logic       borrow_in,   // carry flag for compare with carry
  output logic      [7:0] difference,  // result, used only for flags
  output logic            flag_c,      // borrow out of bit 7
  output logic            flag_h,      // borrow out of bit 3
  output logic            flag_v,      // two's complement overflow
  output logic            flag_n       // sign of difference
);
  // ----------------------------------------
  // ripple borrow chain
  // ----------------------------------------
  logic [8:0] borrow;  // borrow into each bit
  assign borrow[0] = borrow_in;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      // difference bit and borrow out
      assign difference[i] = minuend[i] ^ subtrahend[i] ^ borrow[i];
      assign borrow[i+1]   = (~minuend[i] & subtrahend[i]) | (~minuend[i] & borrow[i])
                           | (subtrahend[i] & borrow[i]);
    end
  endgenerate
  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign flag_c = borrow[8];
  assign flag_h = borrow[4];
  assign flag_n = difference[7];
  assign flag_v = (minuend[7] & ~subtrahend[7] & ~difference[7])
                | (~minuend[7] & subtrahend[7] & difference[7]);
endmodule // csb_cmp_flags
`default_nettype wire

// *** src/csb_exec.sv ***
// compare, skip and branch execution unit with program counter and status flags
`timescale 1ns/10ps
`default_nettype none
`include "csb_params.svh"
module csb_exec
  import csb_pkg::*;
(
  input  wire logic                  mclk,             // core clock
  input  wire logic                  resetn,           // async reset, low
  input  wire logic                  exec_valid,       // instruction present
  input  wire csb_op_t               exec_op,          // decoded operation
  input  wire logic [7:0]            operand_d,        // rd value
  input  wire logic [7:0]            operand_r,        // rr value or immediate
  input  wire logic [7:0]            test_byte,        // working or io reg
  input  wire logic [2:0]            bit_sel,          // bit b or flag s
  input  wire logic [`CSB_OFS_W-1:0] branch_offset,    // signed k
  input  wire logic                  next_is_two_word, // size of next instr
  input  wire logic                  flags_load,       // other unit writes flags
  input  wire logic [7:0]            flags_in,         // value for that write
  output logic [`CSB_PC_W-1:0]       pc,               // program counter
  output logic [7:0]                 status_flags_register, // status flags
  output logic                       skip_taken,       // last instr skipped
  output logic                       branch_taken,     // last instr branched
  output logic                       exec_done         // one-cycle done pulse
);
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // pick one bit of a byte, used for skips and flag tests
  function automatic logic pick_bit(input logic [7:0] val, input logic [2:0] sel);
    pick_bit = val[sel];
  endfunction

  // operation class wires
  wire is_compare = (exec_op == CSB_OP_COMPARE_REGISTERS) ||
                    (exec_op == CSB_OP_COMPARE_WITH_CARRY) ||
                    (exec_op == CSB_OP_COMPARE_WITH_IMMEDIATE);
  wire is_cpc     = (exec_op == CSB_OP_COMPARE_WITH_CARRY);
  wire tested_bit = pick_bit(test_byte, bit_sel);           // skip operand bit
  wire flag_bit   = pick_bit(status_flags_register, bit_sel); // branch flag bit
  wire flag_z_now = status_flags_register[`CSB_FLAG_Z];     // zero flag
  wire flag_c_now = status_flags_register[`CSB_FLAG_C];     // carry flag

  // ----------------------------------------
  // compare subtractor
  // ----------------------------------------
  logic [7:0] cmp_diff;  // discarded difference
  logic       cmp_c;     // borrow
  logic       cmp_h;     // half borrow
  logic       cmp_v;     // overflow
  logic       cmp_n;     // negative
  wire        cmp_borrow_in = is_cpc & flag_c_now;  // only compare with carry

  csb_cmp_flags csb_cmp_flags_i (
    .minuend    (operand_d),
    .subtrahend (operand_r),
    .borrow_in  (cmp_borrow_in),
    .difference (cmp_diff),
    .flag_c     (cmp_c),
    .flag_h     (cmp_h),
    .flag_v     (cmp_v),
    .flag_n     (cmp_n)
  );

  // zero: compare with carry keeps z only if it was already set
  wire cmp_z = (cmp_diff == 8'h00) & (~is_cpc | flag_z_now);

  // ----------------------------------------
  // skip and branch conditions
  // ----------------------------------------
  logic skip_cond;    // skip condition holds
  logic branch_cond;  // branch condition holds
  always_comb begin
    skip_cond   = 1'b0;
    branch_cond = 1'b0;
    unique case (exec_op)
      CSB_OP_SKIP_IF_REG_BIT_CLEAR: skip_cond = ~tested_bit;
      CSB_OP_SKIP_IF_REG_BIT_SET:   skip_cond = tested_bit;
      CSB_OP_SKIP_IF_IO_BIT_CLEAR:  skip_cond = ~tested_bit;
      CSB_OP_SKIP_IF_IO_BIT_SET:    skip_cond = tested_bit;
      CSB_OP_BRANCH_IF_FLAG_SET:    branch_cond = flag_bit;
      CSB_OP_BRANCH_IF_FLAG_CLEAR:  branch_cond = ~flag_bit;
      CSB_OP_BRANCH_IF_EQUAL:       branch_cond = flag_z_now;
      CSB_OP_BRANCH_IF_NOT_EQUAL:   branch_cond = ~flag_z_now;
      CSB_OP_BRANCH_IF_CARRY_SET:   branch_cond = flag_c_now;
      CSB_OP_BRANCH_SAME_OR_HIGHER: branch_cond = ~flag_c_now;
      default: begin
        // other and compare ops: neither skip nor branch
        skip_cond   = 1'b0;
        branch_cond = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // next program counter
  // ----------------------------------------
  // sign-extended offset; the plus one is added in pc_branch
  wire [`CSB_PC_W-1:0] ofs_ext  = {{(`CSB_PC_W-`CSB_OFS_W){branch_offset[`CSB_OFS_W-1]}},
                                   branch_offset};
  // skip length by next instruction size
  wire [`CSB_PC_W-1:0] skip_step = next_is_two_word ? `CSB_STEP_SKIP2 : `CSB_STEP_SKIP1;
  wire [`CSB_PC_W-1:0] pc_seq    = pc + `CSB_STEP_ONE;            // fall through
  wire [`CSB_PC_W-1:0] pc_skip   = pc + skip_step;
  wire [`CSB_PC_W-1:0] pc_branch = pc + ofs_ext + `CSB_STEP_ONE;
  wire [`CSB_PC_W-1:0] next_pc   = skip_cond   ? pc_skip   :
                                   branch_cond ? pc_branch : pc_seq;

  // ----------------------------------------
  // next status flags
  // ----------------------------------------
  logic [7:0] next_flags;  // flag value after this cycle
  always_comb begin
    next_flags = status_flags_register;
    if (exec_valid && is_compare) begin
      // compare writes its five flags only; skips and branches write none
      next_flags[`CSB_FLAG_C] = cmp_c;
      next_flags[`CSB_FLAG_Z] = cmp_z;
      next_flags[`CSB_FLAG_N] = cmp_n;
      next_flags[`CSB_FLAG_V] = cmp_v;
      next_flags[`CSB_FLAG_H] = cmp_h;
    end else if (flags_load) begin
      // another unit writes the flags when no compare runs
      next_flags = flags_in;
    end
  end

  // ----------------------------------------
  // program counter register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pc <= `CSB_PC_RST;
    end else if (exec_valid) begin
      pc <= next_pc;
    end
  end

  // ----------------------------------------
  // status flags register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_flags_register <= `CSB_FLAGS_RST;
    end else begin
      status_flags_register <= next_flags;
    end
  end

  // ----------------------------------------
  // outcome indicators
  // ----------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      skip_taken   <= 1'b0;
      branch_taken <= 1'b0;
      exec_done    <= 1'b0;
    end else begin
      skip_taken   <= exec_valid & skip_cond;
      branch_taken <= exec_valid & branch_cond;
      exec_done    <= exec_valid;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_cmp_zero_flag: assert property (
    exec_valid && exec_op == CSB_OP_COMPARE_REGISTERS && operand_d == operand_r
    |=> status_flags_register[`CSB_FLAG_Z] && !status_flags_register[`CSB_FLAG_C])
    else $error("equal compare did not set zero");
  chk_cmp_borrow: assert property (
    exec_valid && exec_op == CSB_OP_COMPARE_WITH_IMMEDIATE && operand_d < operand_r
    |=> status_flags_register[`CSB_FLAG_C] && pc == $past(pc) + 16'h0001)
    else $error("lower compare did not set carry");
  chk_skip_reg_clear: assert property (
    exec_valid && exec_op == CSB_OP_SKIP_IF_REG_BIT_CLEAR && !test_byte[bit_sel] && !next_is_two_word
    |=> pc == $past(pc) + 16'h0002 && skip_taken)
    else $error("reg bit clear skip wrong");
  chk_skip_reg_set: assert property (
    exec_valid && exec_op == CSB_OP_SKIP_IF_REG_BIT_SET && !test_byte[bit_sel]
    |=> pc == $past(pc) + 16'h0001 && !skip_taken)
    else $error("reg bit set skipped wrongly");
  chk_skip_io_clear: assert property (
    exec_valid && exec_op == CSB_OP_SKIP_IF_IO_BIT_CLEAR && test_byte[bit_sel]
    |=> pc == $past(pc) + 16'h0001)
    else $error("io bit clear skipped wrongly");
  chk_skip_io_two: assert property (
    exec_valid && exec_op == CSB_OP_SKIP_IF_IO_BIT_SET && test_byte[bit_sel] && next_is_two_word
    |=> pc == $past(pc) + 16'h0003)
    else $error("two word skip wrong");
  chk_branch_flags_kept: assert property (
    exec_valid && exec_op[3] && !flags_load |=> $stable(status_flags_register))
    else $error("branch changed flags");
  chk_branch_set: assert property (
    exec_valid && exec_op == CSB_OP_BRANCH_IF_FLAG_SET && status_flags_register[bit_sel]
    |=> pc == $past(pc) + $past(ofs_ext) + 16'h0001 && branch_taken)
    else $error("flag set branch target wrong");
  chk_branch_ne: assert property (
    exec_valid && exec_op == CSB_OP_BRANCH_IF_NOT_EQUAL && status_flags_register[`CSB_FLAG_Z]
    |=> pc == $past(pc) + 16'h0001 && !branch_taken)
    else $error("not equal branched on zero");
  chk_branch_eq: assert property (
    exec_valid && exec_op == CSB_OP_BRANCH_IF_EQUAL && !status_flags_register[`CSB_FLAG_Z]
    |=> !branch_taken)
    else $error("equal branched without zero");
  chk_branch_carry: assert property (
    exec_valid && exec_op == CSB_OP_BRANCH_IF_CARRY_SET && status_flags_register[`CSB_FLAG_C]
    |=> branch_taken && pc == $past(pc) + $past(ofs_ext) + 16'h0001)
    else $error("carry branch not taken");
  chk_branch_sh: assert property (
    exec_valid && exec_op == CSB_OP_BRANCH_SAME_OR_HIGHER && !status_flags_register[`CSB_FLAG_C]
    |=> branch_taken)
    else $error("same or higher not taken");

  cov_skip_two_word:  cover property (exec_valid && skip_cond && next_is_two_word);
  cov_branch_back:    cover property (exec_valid && branch_cond && branch_offset[`CSB_OFS_W-1]);
  cov_cmp_then_branch_if_not_equal:  cover property (exec_valid && is_compare
                                      ##1 exec_valid && exec_op == CSB_OP_BRANCH_IF_NOT_EQUAL);
endmodule // csb_exec
`default_nettype wire
